// ### logic/aicp_top.sv
/*
  i2c slave control port of the amplifier: samples scl and sda with the
  system clock, decodes start and stop, receives and sends bytes, and
  holds the identification and power and clip registers.
  assumes i_clk at 25 MHz, scl no faster than 400 kHz, an external
  pull-up on sda, and a strap pin that is steady around power-up.
*/
`timescale 1ns/10ps
`default_nettype none
`include "aicp_map.svh"
module aicp_top #(
  parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary identification value
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // i2c pins, sda open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // address strap
  input wire logic i_sleep_address_strap_pin,
  // register contents and status
  output aicp_pkg::aicp_power_t o_power,
  output logic o_addr_bit,
  output logic o_busy
);
  import aicp_pkg::*;

  logic scl_s; // synchronised scl
  logic sda_s; // synchronised sda
  logic strap_s; // synchronised strap
  logic scl_q; // scl one cycle back
  logic sda_q; // sda one cycle back
  logic scl_rise; // scl went high
  logic scl_fall; // scl went low
  logic start; // start or repeated start seen
  logic stop; // stop seen
  aicp_ctl_t ctl_q, ctl_d; // byte engine state and its next value
  aicp_power_t power_q, power_d; // power and clip register
  logic wr_en; // a received data byte is written this cycle; only the power offset keeps it
  logic [7:0] rd_data; // byte at the pointer
  logic [1:0] wait_q, wait_d; // strap settle counter
  logic strap_done_q, strap_done_d; // strap has been latched
  logic addr_bit_q, addr_bit_d; // latched low address bit
  // pins pass two flops before any logic sees them
  aicp_sync #(
    .W(3),
    .RST(`AICP_SYNC_RESET)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d({i_scl, i_sda, i_sleep_address_strap_pin}),
    .o_q({scl_s, sda_s, strap_s})
  );
  // previous levels for edge detection
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  // a 400 kHz scl half period is over 30 cycles, so the three cycle
  // sampling delay leaves ample margin at either rate
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  // sda moving while scl stays high marks start and stop
  assign start = scl_s & scl_q & sda_q & ~sda_s;
  assign stop = scl_s & scl_q & ~sda_q & sda_s;
  // strap latch: wait for the synchroniser to fill, then take it once
  always_comb
  begin
    wait_d = wait_q;
    strap_done_d = strap_done_q;
    addr_bit_d = addr_bit_q;
    if (!strap_done_q)
    begin
      if (wait_q == `AICP_STRAP_WAIT)
      begin
        addr_bit_d = strap_s;
        strap_done_d = 1'b1;
      end
      else
      begin
        wait_d = wait_q + 2'h1;
      end
    end
  end
  // strap latch registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wait_q <= 2'h0;
      strap_done_q <= 1'b0;
      addr_bit_q <= 1'b0;
    end
    else
    begin
      wait_q <= wait_d;
      strap_done_q <= strap_done_d;
      addr_bit_q <= addr_bit_d;
    end
  end
  // read mux; unmapped offsets read as zero
  always_comb
  begin
    unique case (ctl_q.ptr)
      `AICP_REG_ID: rd_data = CHIP_ID;
      `AICP_REG_POWER: rd_data = power_q;
      default: rd_data = 8'h00;
    endcase
  end
  // byte engine next state
  always_comb
  begin
    ctl_d = ctl_q;
    wr_en = 1'b0;
    if (start)
    begin
      // start or repeated start restarts address reception
      ctl_d.st = ST_RX;
      ctl_d.phase = PH_ADDR;
      ctl_d.cnt = 4'h0;
      ctl_d.oe = 1'b0;
    end
    else if (stop)
    begin
      // stop always releases the bus
      ctl_d.st = ST_IDLE;
      ctl_d.oe = 1'b0;
    end
    else
    begin
      unique case (ctl_q.st)
        ST_IDLE: ctl_d.st = ST_IDLE; // bytes for another slave are ignored
        ST_RX:
        begin
          if (scl_rise)
          begin
            // msb arrives first
            ctl_d.sh = {ctl_q.sh[6:0], sda_s};
            ctl_d.cnt = ctl_q.cnt + 4'h1;
          end
          else if (scl_fall && ctl_q.cnt == `AICP_BYTE_BITS)
          begin
            // byte complete; pull sda low for the ninth clock
            ctl_d.st = ST_ACK;
            ctl_d.oe = 1'b1;
            unique case (ctl_q.phase)
              PH_ADDR:
              begin
                ctl_d.rw = ctl_q.sh[0];
                if (ctl_q.sh[7:1] != {`AICP_ADDR_PREFIX, addr_bit_q})
                begin
                  ctl_d.st = ST_IDLE;
                  ctl_d.oe = 1'b0;
                end
              end
              PH_REG:
              begin
                ctl_d.ptr = ctl_q.sh;
              end
              PH_DATA:
              begin
                wr_en = 1'b1;
                ctl_d.ptr = ctl_q.ptr + 8'h01;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            // ninth clock over, release and go on
            ctl_d.oe = 1'b0;
            ctl_d.cnt = 4'h0;
            if (ctl_q.phase == PH_ADDR && ctl_q.rw)
            begin
              // read: first bit goes out in this low phase
              ctl_d.st = ST_TX;
              ctl_d.sh = rd_data;
              ctl_d.oe = ~rd_data[7];
              ctl_d.ptr = ctl_q.ptr + 8'h01;
            end
            else
            begin
              ctl_d.st = ST_RX;
              // any number of data bytes may follow the register byte
              unique case (ctl_q.phase)
                PH_ADDR: ctl_d.phase = PH_REG;
                PH_REG: ctl_d.phase = PH_DATA;
                PH_DATA: ctl_d.phase = PH_DATA;
              endcase
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            ctl_d.cnt = ctl_q.cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (ctl_q.cnt == `AICP_BYTE_BITS)
            begin
              // hand sda to the master for its acknowledge
              ctl_d.st = ST_MACK;
              ctl_d.oe = 1'b0;
            end
            else
            begin
              // next bit only while scl is low
              ctl_d.sh = {ctl_q.sh[6:0], 1'b0};
              ctl_d.oe = ~ctl_q.sh[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            ctl_d.ack = ~sda_s;
          end
          else if (scl_fall)
          begin
            ctl_d.cnt = 4'h0;
            if (ctl_q.ack)
            begin
              // master wants more; send the next register
              ctl_d.st = ST_TX;
              ctl_d.sh = rd_data;
              ctl_d.oe = ~rd_data[7];
              ctl_d.ptr = ctl_q.ptr + 8'h01;
            end
            else
            begin
              // nack: stay off the bus until the next start
              ctl_d.st = ST_IDLE;
            end
          end
        end
      endcase
    end
  end
  // byte engine registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      // every field idles low except the two state codes
      ctl_q <= '{st: ST_IDLE, phase: PH_ADDR, default: '0};
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end
  // register write; the identification byte is read only
  always_comb
  begin
    power_d = power_q;
    if (wr_en && ctl_q.ptr == `AICP_REG_POWER)
    begin
      power_d = aicp_power_t'(ctl_q.sh);
    end
  end
  // power and clip register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      power_q <= `AICP_POWER_RESET;
    end
    else
    begin
      power_q <= power_d;
    end
  end
  // open drain: only ever pulls low, never touches scl
  assign o_sda_out = 1'b0;
  assign o_sda_oe = ctl_q.oe;
  assign o_power = power_q;
  assign o_addr_bit = addr_bit_q;
  assign o_busy = ~ctl_q.st[0];
  // a foreign address drops the engine to idle
  addr_match_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (ctl_q.st == ST_RX && !start && !stop && scl_fall && ctl_q.cnt == `AICP_BYTE_BITS
      && ctl_q.phase == PH_ADDR && ctl_q.sh[7:1] != {`AICP_ADDR_PREFIX, addr_bit_q})
    |=> ctl_q.st == ST_IDLE && !o_sda_oe)
    else $error("foreign address was answered");
  // address bit never moves once latched
  strap_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $past(strap_done_q) |-> strap_done_q && $stable(addr_bit_q))
    else $error("latched address bit changed");
  // sda drive changes only after scl went low
  sda_low_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $changed(o_sda_oe) && !$past(start) && !$past(stop) |-> !$past(scl_s))
    else $error("sda drive changed while scl high");
  // acknowledge holds sda low throughout
  ack_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ctl_q.st == ST_ACK |-> o_sda_oe)
    else $error("acknowledge not driven");
  // transmitted bit is always the top of the shift register
  tx_msb_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ctl_q.st == ST_TX |-> o_sda_oe == ~ctl_q.sh[7])
    else $error("sent bit is not msb");
  // a stored byte lands in the power register
  write_store_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_en && ctl_q.ptr == `AICP_REG_POWER |=> power_q == $past(ctl_q.sh))
    else $error("write data not stored");
  // pointer steps by one after each data byte
  ptr_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_en |=> ctl_q.ptr == $past(ctl_q.ptr) + 8'h01)
    else $error("pointer did not advance");
  // read loads the addressed byte after the address ack
  read_load_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ctl_q.st == ST_ACK && scl_fall && !start && !stop && ctl_q.rw && ctl_q.phase == PH_ADDR
    |=> ctl_q.st == ST_TX && ctl_q.sh == $past(rd_data))
    else $error("read data not loaded");
  // stop releases the bus next cycle
  stop_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
    stop && !start |=> ctl_q.st == ST_IDLE && !o_sda_oe)
    else $error("stop did not release bus");

endmodule
`default_nettype wire

// ### logic/aicp_map.svh
/*
  constants of the amplifier i2c control port: register offsets, reset
  values, address prefix and small counts, all as macros.
  assumes it is included by its bare name from the top module.
*/
// Notes on behaviour
// - answer address 110110 plus strap bit
// - strap level latched once after power-up
// - works at 100 kHz and 400 kHz
// - slave only, never stretches the clock
// - bytes msb first, each then acknowledged
// - sda moves only while scl low
// - ack holds sda low whole ninth clock
// - any byte count between start and stop
// - write: address, register, data, then stop
// - read: register write, restart, then data out
`ifndef AICP_MAP_SVH
`define AICP_MAP_SVH

// register offsets
`define AICP_REG_ID 8'h00
`define AICP_REG_POWER 8'h01

// reset value of the power and clip register
`define AICP_POWER_RESET 8'hfd

// upper six bits of the seven-bit slave address
`define AICP_ADDR_PREFIX 6'h36

// bits in a byte, counted on scl rising edges
`define AICP_BYTE_BITS 4'h8

// cycles after reset before the synchronised strap is trusted
`define AICP_STRAP_WAIT 2'h3

// synchroniser reset value: scl, sda, strap all idle high
`define AICP_SYNC_RESET 3'h7

`endif

// ### logic/aicp_pkg.sv
/*
  types of the amplifier i2c control port: state encodings and the
  packed structs that carry control state and the power register.
  assumes aicp_map.svh is on the include path.
*/
`default_nettype none
package aicp_pkg;

  // byte engine states, one-hot
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } aicp_state_t;

  // which byte of a write frame is being received
  typedef enum logic [2:0]
  {
    PH_ADDR = 3'h1,
    PH_REG  = 3'h2,
    PH_DATA = 3'h4
  } aicp_phase_t;

  // control state of the byte engine
  typedef struct packed
  {
    aicp_state_t st;
    aicp_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic ack;
    logic oe;
  } aicp_ctl_t;

  // power and clip register layout
  typedef struct packed
  {
    logic [5:0] clip_high;
    logic speaker_sleep_bit;
    logic speaker_shutdown_bit;
  } aicp_power_t;

endpackage
`default_nettype wire

// ### logic/aicp_sync.sv
/*
  two flip-flop synchroniser for a group of asynchronous pin levels.
  assumes the inputs are levels; only the second stage is visible.
*/
`timescale 1ns/10ps
`default_nettype none
module aicp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // asynchronous levels in, synchronised out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q; // first stage, read only by the second
  logic [W-1:0] sync_q; // second stage

  // two stages, reset to the idle level of the pins
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_q <= RST;
      sync_q <= RST;
    end
    else
    begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule
`default_nettype wire

// ### verif/aicp_master.sv
/*
  behavioural i2c master driving scl and sda of the control port.
  assumes sda released means high through the pull-up, and that the
  bench sets half (scl half period, in i_clk cycles) between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module aicp_master (
  // system clock, used only as a time base
  input wire logic i_clk,
  // wire level of sda
  input wire logic i_sda,
  // master pins, 1 means released
  output logic o_scl,
  output logic o_sda
);
  int half = 8; // scl half period in cycles

  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // all pin moves land on falling edges, away from the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // start, also used as repeated start from scl low
  task automatic start();
    tick(half / 2);
    o_sda = 1'b1;
    tick(half / 2);
    o_scl = 1'b1;
    tick(half / 2);
    o_sda = 1'b0;
    tick(half / 2);
    o_scl = 1'b0;
  endtask

  // stop, releasing the bus at the end of each transfer
  task automatic stop();
    tick(half / 2);
    o_sda = 1'b0;
    tick(half / 2);
    o_scl = 1'b1;
    tick(half / 2);
    o_sda = 1'b1;
    tick(half);
  endtask

  // one bit; low tells whether sda stayed low over the whole high phase
  task automatic bit_io(input logic b, output logic r, output logic low);
    tick(half / 2);
    o_sda = b;
    tick(half - half / 2);
    o_scl = 1'b1; // no wait for stretching
    low = 1'b1;
    r = 1'b0;
    for (int k = 0; k < half; k++)
    begin
      @(negedge i_clk);
      if (k == half / 2) r = i_sda;
      if (i_sda !== 1'b0) low = 1'b0;
    end
    o_scl = 1'b0;
  endtask

  // send a byte msb first, then read the ack bit
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r, ack);
    bit_io(1'b1, r, ack);
  endtask

  // receive a byte, then ack (mack high) or nack it
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic a;
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i], a);
    bit_io(~mack, r, a);
  endtask
endmodule
`default_nettype wire

// ### verif/test_amp_i2c_control_port.sv
/*
  self-checking bench of the i2c control port: a master model runs
  frames, a register model predicts acks, read data and o_power.
  assumes scl phases of at least 6 cycles, so the fastest link here
  uses 8-cycle phases, a 640 ns period, faster than 400 kHz.
*/
`timescale 1ns/10ps
`default_nettype none
module test_amp_i2c_control_port;
  import aicp_pkg::*;
  localparam logic [7:0] CHIP_ID = 8'ha7; // arbitrary value
  logic i_clk, i_reset, strap, scl, m_sda, sda_w, oe, sda_out, abit, busy;
  aicp_power_t power;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'hce82bd6c;
  logic [7:0] m_power; // model of register 0x01
  logic m_abit;
  int m_ptr;
  logic [7:0] wq[$];
  logic oe_p = 1'b0; // device drive one edge back
  logic scl_p = 1'b1; // scl pin one edge back

  // open drain: the device can only pull the wire low
  assign sda_w = oe ? (sda_out & m_sda) : m_sda;

  aicp_top #(.CHIP_ID(CHIP_ID)) aicp_top_inst (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl),
    .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(oe), .i_sleep_address_strap_pin(strap),
    .o_power(power), .o_addr_bit(abit), .o_busy(busy));
  aicp_master aicp_master_inst (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // the device may only move sda while scl is low
  always @(posedge i_clk)
  begin
    // outputs are unknown before the first reset edge, so skip reset
    if (!i_reset && scl && scl_p && oe !== oe_p)
    begin
      error_cnt++;
      $display("ERROR sda_move expected %b seen %b", oe_p, oe);
    end
    oe_p <= oe;
    scl_p <= scl;
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic [7:0] m_read(input int p);
    return (p == 0) ? CHIP_ID : (p == 1) ? m_power : 8'h00;
  endfunction

  // reset as power-up, then move the strap to show it is not re-read
  task automatic do_reset(input logic s);
    @(negedge i_clk);
    strap = s;
    i_reset = 1'b1;
    repeat (5) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (8) @(negedge i_clk);
    m_abit = s;
    m_power = 8'hfd;
    chk8("power_rst", m_power, power);
    strap = ~s;
    repeat (4) @(negedge i_clk);
    chk1("addr_bit", m_abit, abit);
  endtask

  // write frame: address, offset, then the bytes of wq
  task automatic wr(input logic [6:0] a, input logic [7:0] off);
    logic ack;
    logic hit;
    hit = (a == {6'h36, m_abit});
    aicp_master_inst.start();
    aicp_master_inst.wr_byte({a, 1'b0}, ack);
    chk1("addr_ack", hit, ack);
    chk1("busy_on", hit, busy);
    if (hit)
    begin
      aicp_master_inst.wr_byte(off, ack);
      chk1("reg_ack", 1'b1, ack);
      m_ptr = off;
      foreach (wq[i])
      begin
        aicp_master_inst.wr_byte(wq[i], ack);
        chk1("data_ack", 1'b1, ack);
        if (m_ptr == 1) m_power = wq[i];
        m_ptr = (m_ptr + 1) % 256;
      end
    end
    aicp_master_inst.stop();
    repeat (6) @(negedge i_clk);
    chk8("power", m_power, power);
    chk1("busy", 1'b0, busy);
  endtask

  // read frame: offset write, repeated start, n bytes, nack on the last
  task automatic rd(input logic [6:0] a, input logic [7:0] off, input int n);
    logic ack;
    logic [7:0] d;
    aicp_master_inst.start();
    aicp_master_inst.wr_byte({a, 1'b0}, ack);
    aicp_master_inst.wr_byte(off, ack);
    m_ptr = off;
    aicp_master_inst.start();
    aicp_master_inst.wr_byte({a, 1'b1}, ack);
    chk1("rd_ack", 1'b1, ack);
    for (int i = 0; i < n; i++)
    begin
      aicp_master_inst.rd_byte(i < n - 1, d);
      chk8("rdata", m_read(m_ptr), d);
      m_ptr = (m_ptr + 1) % 256;
    end
    aicp_master_inst.stop();
    repeat (6) @(negedge i_clk);
    chk1("busy", 1'b0, busy);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    int halves[3];
    halves = '{8, 32, 125};
    i_reset = 1'b1;
    strap = 1'b0;
    do_reset(1'b0);
    // fast, then about 400 kHz, then 100 kHz
    foreach (halves[k])
    begin
      aicp_master_inst.half = halves[k];
      wq = {8'($random(seed))};
      wr(7'h6c, 8'h01);
      rd(7'h6c, 8'h01, 1);
    end
    aicp_master_inst.half = 8;
    wr(7'h6d, 8'h01);
    // id write dropped, pointer steps into 0x01 then past it
    wq = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
    wr(7'h6c, 8'h00);
    rd(7'h6c, 8'h00, 3);
    do_reset(1'b1);
    wq = {8'($random(seed))};
    wr(7'h6c, 8'h01);
    wr(7'h6d, 8'h01);
    rd(7'h6d, 8'h00, 2);
    stop_test();
  end
endmodule
`default_nettype wire
